/* File: src/hib_rtc_map.svh */
// register offsets, field positions, reset values and timing counts
// of the sleep module seconds counter; included by the package users.
`ifndef HIB_RTC_MAP_SVH
`define HIB_RTC_MAP_SVH

// byte offsets on the register bus (one aligned word each)
`define OFS_COUNTER 8'h00
`define OFS_MATCH0 8'h04
`define OFS_MATCH1 8'h08
`define OFS_LOAD 8'h0c
`define OFS_CONTROL 8'h10
`define OFS_RAW_STATUS 8'h14
`define OFS_STATUS_CLEAR 8'h18
`define OFS_TRIM 8'h1c
`define OFS_MEM_BASE 8'h40

// word index width and memory window
`define WIDX_W 6
`define MEM_WORDS 16
`define MEM_IDX_W 4
`define MEM_SEL 2'b01

// control register fields
`define CTL_RTC_EN 0
`define CTL_CLK_EN 1
`define CTL_SLEEP_REQ 2
`define CTL_WAKE_MATCH 3
`define CTL_WAKE_EXT 4
`define CTL_WRITE_COMPLETE 31

// raw status fields
`define RIS_MATCH0 0
`define RIS_MATCH1 1
`define RIS_EXT_WAKE 3
`define RIS_W 4

// timing: the seconds counter steps once per second of the slow clock
`define SLOW_CLK_HZ 32768
`define SECOND_S 1
`define SECOND_TICKS (`SECOND_S * `SLOW_CLK_HZ)
`define TRIM_W 16
`define TRIM_RESET 16'h7fff

// reset values
`define WORD_RESET 32'h00000000
`define RIS_RESET 4'h0

`endif

/* File: src/hib_rtc_pkg.sv */
// types shared by the sleep module seconds counter and its bus side.
// assumes the map header supplies the widths.
`include "hib_rtc_map.svh"

package hib_rtc_pkg;

   typedef logic [31:0] word_t;
   typedef logic [`WIDX_W-1:0] word_idx_t;

   // run: core awake; asleep: sleep request output held high
   typedef enum logic [0:0] {
      mode_run = 1'b0,
      mode_asleep = 1'b1
   } mode_t;

endpackage

/* File: src/pin_sync.sv */
// two-flop synchroniser with rising edge pulse for pins and slow clocks.
// assumes the input is asynchronous to clk; rise looks at the second
// flop and later only.
`timescale 1ns/1ps

module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
      logic [WIDTH-1:0] last;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // shift chain; meta feeds only the stable stage
   always_comb begin
      next_s = s;
      next_s.meta = pin;
      next_s.stable = s.meta;
      next_s.last = s.stable;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.stable;
   assign rise = s.stable & ~s.last;

endmodule

/* File: src/hibernate_rtc_sync.sv */
// sleep module seconds counter with wake cause reporting and write
// hand-over into the slow clock timing, reached over avalon-mm.
// assumes slow_clk and ext_wake_n are asynchronous pins; software
// follows the read-back and safe-window discipline for its writes.
`timescale 1ns/1ps
`include "hib_rtc_map.svh"

// Function
// - raw status flags only the real wake source
// - hand writes to slow timing, flag completion
// - write at counter step keeps counter intact
// - counter steps each second, match raises interrupt
// - own slow clock; disable stops it, memory kept
module hibernate_rtc_sync (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire hib_rtc_pkg::word_t writedata,
   output hib_rtc_pkg::word_t readdata,
   output logic waitrequest,
   input wire logic slow_clk,
   input wire logic ext_wake_n,
   output logic sleep_request,
   output logic match_irq
);
   import hib_rtc_pkg::*;

   typedef struct packed {
      mode_t mode;
      word_t counter;
      word_t match0;
      word_t match1;
      word_t load;
      logic [`TRIM_W-1:0] trim;
      logic [`TRIM_W-1:0] prescale;
      logic rtc_en;
      logic clk_en;
      logic wake_match;
      logic wake_ext;
      logic [`RIS_W-1:0] raw;
      logic pend;
      word_idx_t pend_idx;
      word_t pend_data;
      logic rd_done;
      word_t rdata;
      logic [`MEM_WORDS-1:0][31:0] mem;
   } hib_state_t;

   localparam hib_state_t STATE_RESET = '{
      mode: mode_run,
      counter: `WORD_RESET,
      match0: `WORD_RESET,
      match1: `WORD_RESET,
      load: `WORD_RESET,
      trim: `TRIM_RESET,
      prescale: '0,
      rtc_en: 1'b0,
      clk_en: 1'b0,
      wake_match: 1'b0,
      wake_ext: 1'b0,
      raw: `RIS_RESET,
      pend: 1'b0,
      pend_idx: '0,
      pend_data: `WORD_RESET,
      rd_done: 1'b0,
      rdata: `WORD_RESET,
      mem: '0
   };

   localparam word_idx_t IDX_COUNTER = word_idx_t'(`OFS_COUNTER >> 2);
   localparam word_idx_t IDX_MATCH0 = word_idx_t'(`OFS_MATCH0 >> 2);
   localparam word_idx_t IDX_MATCH1 = word_idx_t'(`OFS_MATCH1 >> 2);
   localparam word_idx_t IDX_LOAD = word_idx_t'(`OFS_LOAD >> 2);
   localparam word_idx_t IDX_CONTROL = word_idx_t'(`OFS_CONTROL >> 2);
   localparam word_idx_t IDX_RAW = word_idx_t'(`OFS_RAW_STATUS >> 2);
   localparam word_idx_t IDX_CLEAR = word_idx_t'(`OFS_STATUS_CLEAR >> 2);
   localparam word_idx_t IDX_TRIM = word_idx_t'(`OFS_TRIM >> 2);

   hib_state_t s;
   hib_state_t next_s;

   logic slow_rise;
   logic slow_level;
   logic ext_wake_fall;
   logic raw_set_ext_unused;
   logic ext_wake_rise;
   logic ext_wake_seen;
   word_idx_t widx;
   logic is_mem;
   logic affected;
   logic wr_take;
   logic tick;
   logic apply;
   logic second;
   word_t counter_step;
   logic [`RIS_W-1:0] raw_set;
   logic [`RIS_W-1:0] raw_clr;
   word_t read_mux;

   // slow clock is sampled, not used as a clock: the whole block
   // stays on clk, so nothing has to cross between domains
   pin_sync #(
      .WIDTH(2)
   ) u_pins (
      .clk(clk),
      .rstn(rstn),
      .pin({slow_clk, ~ext_wake_n}),
      .level({slow_level, ext_wake_fall}),
      .rise({slow_rise, raw_set_ext_unused})
   );

   // bus decode
   assign widx = address[7:2];
   assign is_mem = (address[7:6] == `MEM_SEL);
   assign affected = is_mem || widx == IDX_COUNTER || widx == IDX_MATCH0 ||
      widx == IDX_MATCH1 || widx == IDX_LOAD || widx == IDX_TRIM;

   // reads take one wait cycle so read data comes from a flop;
   // a second slow-side write stalls until the first has landed
   assign waitrequest = (read && !s.rd_done) || (write && affected && s.pend);
   assign wr_take = write && !waitrequest;

   // slow clock edge only counts while the module clock is enabled
   assign tick = slow_rise && s.clk_en;
   // with the slow clock stopped nothing would ever land the write
   assign apply = s.pend && (tick || !s.clk_en);
   assign second = tick && s.rtc_en && (s.prescale == s.trim);
   assign counter_step = s.counter + 32'h00000001;

   // read multiplexer
   always_comb begin
      read_mux = `WORD_RESET;
      if (is_mem) begin
         read_mux = s.mem[address[`MEM_IDX_W+1:2]];
      end else begin
         unique case (widx)
            IDX_COUNTER: read_mux = s.counter;
            IDX_MATCH0: read_mux = s.match0;
            IDX_MATCH1: read_mux = s.match1;
            IDX_LOAD: read_mux = s.load;
            IDX_TRIM: read_mux = {16'h0000, s.trim};
            IDX_RAW: read_mux = {28'h0000000, s.raw};
            IDX_CONTROL: begin
               read_mux[`CTL_RTC_EN] = s.rtc_en;
               read_mux[`CTL_CLK_EN] = s.clk_en;
               read_mux[`CTL_SLEEP_REQ] = (s.mode == mode_asleep);
               read_mux[`CTL_WAKE_MATCH] = s.wake_match;
               read_mux[`CTL_WAKE_EXT] = s.wake_ext;
               read_mux[`CTL_WRITE_COMPLETE] = !s.pend;
            end
            default: read_mux = `WORD_RESET;
         endcase
      end
   end

   // status events: each flag is raised only by its own source
   always_comb begin
      raw_set = '0;
      raw_clr = '0;
      if (second && counter_step == s.match0) begin
         raw_set[`RIS_MATCH0] = 1'b1;
      end
      if (second && counter_step == s.match1) begin
         raw_set[`RIS_MATCH1] = 1'b1;
      end
      // the external flag sets on an external wake and nothing else
      if (s.mode == mode_asleep && s.wake_ext && ext_wake_rise) begin
         raw_set[`RIS_EXT_WAKE] = 1'b1;
      end
      if (wr_take && widx == IDX_CLEAR) begin
         raw_clr = writedata[`RIS_W-1:0];
      end
   end

   // external wake pin is active low; sample its asserted level edge
   assign ext_wake_rise = ext_wake_fall && !ext_wake_seen;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_wake_seen <= 1'b0;
      end else begin
         ext_wake_seen <= ext_wake_fall;
      end
   end

   // next state
   always_comb begin
      next_s = s;

      // read answer, captured once per request and kept in rdata until the next read
      if (read && !s.rd_done) begin
         next_s.rd_done = 1'b1;
         next_s.rdata = read_mux;
      end else begin
         next_s.rd_done = 1'b0;
      end

      // prescaler runs off the enabled slow clock
      if (tick && s.rtc_en) begin
         next_s.prescale = second ? '0 : s.prescale + 16'h0001;
      end
      if (second) begin
         next_s.counter = counter_step;
      end

      // landing a held write at the slow edge; a counter or load
      // write replaces the stepped value whole, any other write
      // leaves the step untouched
      if (apply) begin
         next_s.pend = 1'b0;
         if (s.pend_idx[`WIDX_W-1:`WIDX_W-2] == `MEM_SEL) begin
            next_s.mem[s.pend_idx[`MEM_IDX_W-1:0]] = s.pend_data;
         end else begin
            unique case (s.pend_idx)
               IDX_COUNTER: next_s.counter = s.pend_data;
               IDX_LOAD: begin
                  next_s.load = s.pend_data;
                  next_s.counter = s.pend_data;
                  next_s.prescale = '0;
               end
               IDX_MATCH0: next_s.match0 = s.pend_data;
               IDX_MATCH1: next_s.match1 = s.pend_data;
               IDX_TRIM: next_s.trim = s.pend_data[`TRIM_W-1:0];
               default: next_s.pend = 1'b0;
            endcase
         end
      end

      // bus writes: slow-side registers are held, the rest land now
      if (wr_take) begin
         if (affected) begin
            next_s.pend = 1'b1;
            next_s.pend_idx = widx;
            next_s.pend_data = writedata;
         end else if (widx == IDX_CONTROL) begin
            next_s.rtc_en = writedata[`CTL_RTC_EN];
            next_s.clk_en = writedata[`CTL_CLK_EN];
            next_s.wake_match = writedata[`CTL_WAKE_MATCH];
            next_s.wake_ext = writedata[`CTL_WAKE_EXT];
            if (writedata[`CTL_SLEEP_REQ]) begin
               next_s.mode = mode_asleep;
            end
         end
      end

      // a new event wins over a clear in the same cycle
      next_s.raw = (s.raw & ~raw_clr) | raw_set;

      // wake from sleep on an enabled source
      if (s.mode == mode_asleep) begin
         if (raw_set[`RIS_EXT_WAKE] ||
             (s.wake_match && (raw_set[`RIS_MATCH0] || raw_set[`RIS_MATCH1]))) begin
            next_s.mode = mode_run;
         end
      end
   end

   // single state register; memory is cleared only by rstn
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign readdata = s.rdata;
   assign sleep_request = (s.mode == mode_asleep);
   // match interrupt stays up until software clears the match flags
   assign match_irq = s.raw[`RIS_MATCH0] | s.raw[`RIS_MATCH1];

endmodule

/* File: tb/hib_rtc_chk_sva.sv */
// checker: bus timing, sleep entry and match level of the seconds counter.
// assumes one clk domain; sees only the top module ports.
`timescale 1ns/1ps

module hib_rtc_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire hib_rtc_pkg::word_t writedata,
   input wire hib_rtc_pkg::word_t readdata,
   input wire logic waitrequest,
   input wire logic sleep_request,
   input wire logic match_irq
);
   import hib_rtc_pkg::*;
   logic [5:0] widx;
   logic clr;
   logic slow_wr;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // slow-side words: counter to load, trim and the memory window
   assign widx = address[7:2];
   assign clr = write && widx == 6'h06;
   assign slow_wr = write && (widx < 6'h04 || widx == 6'h07 || widx[5:4] == 2'b01);

   chk_read_wait: assert property (read && !$past(read) |-> waitrequest ##1 !waitrequest)
      else $error("read answer not one cycle late");
   chk_fast_nowait: assert property (write && !slow_wr |-> !waitrequest)
      else $error("fast write stalled");
   chk_wait_cause: assert property (waitrequest |-> read || slow_wr)
      else $error("stall without a request");
   chk_stall_bound: assert property (slow_wr && waitrequest |-> ##[1:40] !waitrequest)
      else $error("held write never landed");
   chk_rd_stable: assert property (!read |=> $stable(readdata))
      else $error("read data moved without a read");
   chk_sleep_enter: assert property (write && widx == 6'h04 && writedata[2] |-> ##[1:2] sleep_request)
      else $error("sleep request not raised");
   chk_irq_hold: assert property (match_irq && !clr && !$past(clr) |=> match_irq)
      else $error("match level dropped without a clear");
   chk_irq_clear: assert property (clr && writedata[1:0] == 2'h3 |-> ##2 !match_irq)
      else $error("match level survived its clear");
   // main scenarios reached
   cover property ($rose(match_irq));
   cover property ($fell(sleep_request));
   cover property (slow_wr && waitrequest);
endmodule

bind hibernate_rtc_sync hib_rtc_chk chk_u (.clk(clk), .rstn(rstn), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .sleep_request(sleep_request), .match_irq(match_irq));

/* File: tb/hibernate_rtc_sync_bench.sv */
// self-checking bench for the seconds counter over avalon-mm.
// assumes the checker is bound; slow_clk is made here from clk.
`timescale 1ns/1ps

module hibernate_rtc_sync_bench;
   import hib_rtc_pkg::*;
   logic clk = 0;
   logic rstn = 0;
   logic [7:0] address = 8'h00;
   logic read = 0;
   logic write = 0;
   word_t writedata = 32'h0;
   word_t readdata;
   logic waitrequest;
   logic slow_clk = 0;
   logic ext_wake_n = 1;
   logic sleep_request;
   logic match_irq;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   int seed = 10646;
   int t0;
   word_t exp_q[$];
   word_t mem[4];
   word_t v;

   hibernate_rtc_sync dut_u (.clk(clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .slow_clk(slow_clk), .ext_wake_n(ext_wake_n),
      .sleep_request(sleep_request), .match_irq(match_irq));

   always #2 clk = ~clk;

   // slow pin of 10 clk period, exact so second lengths are known
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 5 == 4) slow_clk <= ~slow_clk;
      if (cyc == 20000) begin
         errors = errors + 1;
         print_verdict();
      end
   end

   task automatic check(input word_t seen, input word_t expv);
      check_count = check_count + 1;
      if (seen !== expv) begin
         errors = errors + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic print_verdict();
      if (errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // one transfer, held until waitrequest is seen low; idle edge after
   task automatic bus(input logic [7:0] a, input logic w, input word_t d);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input word_t d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input word_t e);
      exp_q.push_back(e);
      bus(a, 1'b0, 32'h0);
   endtask

   task automatic wait_for(input int n);
      repeat (n) @(posedge clk);
   endtask

   // bounded wait on the match level or the sleep request
   task automatic wait_sig(input bit irq, input logic lv);
      int n;
      n = 0;
      while (((irq ? match_irq : sleep_request) !== lv) && n < 400) begin
         @(posedge clk);
         n = n + 1;
      end
      check(n < 400, 32'h1);
   endtask

   task automatic pulse_ext();
      ext_wake_n <= 1'b0;
      wait_for(4);
      ext_wake_n <= 1'b1;
      wait_for(4);
   endtask

   // answers are compared in order against the notes left by rd
   always @(posedge clk) begin
      if (read && waitrequest === 1'b0) begin
         check(readdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // reset contents, unmapped place ignored
      rd(8'h00, 32'h0);
      rd(8'h10, 32'h80000000);
      rd(8'h14, 32'h0);
      rd(8'h1c, 32'h00007fff);
      wr(8'h30, 32'hffffffff);
      rd(8'h30, 32'h0);
      // memory words back to back, then read back
      for (int i = 0; i < 4; i++) begin
         mem[i] = $random(seed);
         wr(8'h40 + 8'(i * 4), mem[i]);
      end
      wait_for(16);
      for (int i = 0; i < 4; i++) rd(8'h40 + 8'(i * 4), mem[i]);
      // seconds of two slow ticks, matches at 3 and 5; setup first
      wr(8'h10, 32'h2);
      wr(8'h1c, 32'h1);
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h5);
      wr(8'h0c, 32'h0);
      wait_for(16);
      rd(8'h10, 32'h80000002);
      rd(8'h08, 32'h5);
      wr(8'h10, 32'h3);
      wait_sig(1, 1);
      t0 = cyc;
      rd(8'h00, 32'h3);
      rd(8'h14, 32'h1);
      wr(8'h18, 32'h3);
      rd(8'h14, 32'h0);
      wait_sig(1, 1);
      check(cyc - t0, 32'd40);
      rd(8'h14, 32'h2);
      wr(8'h18, 32'h3);
      // load while running keeps the whole value
      v = $random(seed);
      wr(8'h1c, 32'hf);
      wr(8'h0c, v);
      wait_for(16);
      rd(8'h00, v);
      // external pin while awake flags nothing; asleep it wakes alone
      pulse_ext();
      rd(8'h14, 32'h0);
      wr(8'h10, 32'h17);
      wait_sig(0, 1);
      pulse_ext();
      wait_sig(0, 0);
      rd(8'h14, 32'h8);
      wr(8'h18, 32'hf);
      // second wake from the match must not flag the pin
      wr(8'h0c, v);
      wr(8'h04, v + 32'h1);
      wait_for(16);
      wr(8'h10, 32'h0f);
      wait_sig(0, 1);
      wait_sig(0, 0);
      rd(8'h14, 32'h1);
      // slow clock off: writes land at once, memory kept
      wr(8'h10, 32'h0);
      rd(8'h10, 32'h80000000);
      wr(8'h4c, v);
      rd(8'h4c, v);
      rd(8'h40, mem[0]);
      print_verdict();
   end
endmodule
